// >>> dv/seq_mem_model.sv
// Purpose: Program and data memory model beside the sequencer.
// Assumes: Answers within the phase the address is set.
// Notes: Only the low 256 bytes of each space are modelled.
module seq_mem_model
	import seq_pkg::*;
(
	// Clock
	input wire logic clock,
	// Program side
	input wire logic [PC_W-1:0] prog_addr,
	output logic [IW_W-1:0] prog_rdata,
	input wire logic [PC_W-1:0] byte_ptr,
	output logic [7:0] prog_byte_rdata,
	input wire logic byte_we,
	input wire logic [7:0] byte_wdata,
	// Data side
	input wire logic [DA_W-1:0] data_addr,
	input wire logic data_re,
	output logic [7:0] data_rdata,
	input wire logic data_we,
	input wire logic [7:0] data_wdata
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] pmem [0:255];
	logic [7:0] dmem [0:255];
	int byte_writes;
	int data_writes;
	logic [7:0] last_byte;
	// Low byte of each word sits at the even address
	assign prog_rdata = {pmem[{prog_addr[7:1], 1'b1}], pmem[{prog_addr[7:1], 1'b0}]};
	assign prog_byte_rdata = pmem[byte_ptr[7:0]];
	// Unselected data bus shows the inverted addressed byte
	assign data_rdata = data_re ? dmem[data_addr[7:0]] : ~dmem[data_addr[7:0]];
	initial begin
		byte_writes = 0;
		data_writes = 0;
		last_byte = 8'h00;
		for (int i = 0; i < 256; i++) begin
			pmem[i] = 8'h00;
			dmem[i] = 8'h00;
		end
	end
	always @(posedge clock) begin
		if (byte_we) begin
			pmem[byte_ptr[7:0]] <= byte_wdata;
			last_byte <= byte_wdata;
			byte_writes <= byte_writes + 1;
		end
		if (data_we) begin
			dmem[data_addr[7:0]] <= data_wdata;
			data_writes <= data_writes + 1;
		end
	end
	task automatic load_word(input logic [7:0] a, input logic [15:0] w);
		pmem[a] = w[7:0];
		pmem[a + 8'h01] = w[15:8];
	endtask : load_word
endmodule : seq_mem_model

// >>> dv/test_cpu_fetch_execute_sequencer.sv
// Purpose: Self-checking bench for the fetch/execute sequencer.
// Assumes: Relative branch and table opcodes as in the package.
// Notes: Fetch trace rows first, then table, reset cases.
module test_cpu_fetch_execute_sequencer
	import seq_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct packed {
		logic [PC_W-1:0] addr;
		logic flush;
	} row_type;
	logic clock;
	logic arst_n;
	logic [PC_W-1:0] prog_addr_q;
	logic [IW_W-1:0] prog_rdata;
	logic [7:0] prog_byte_rdata;
	logic prog_byte_we_q;
	logic [7:0] prog_byte_wdata_q;
	logic [DA_W-1:0] data_addr_q;
	logic data_re_q;
	logic [7:0] data_rdata;
	logic data_we_q;
	logic [7:0] data_wdata_q;
	phase_type phase_q;
	phase_type prev_ph;
	logic ph_ok;
	logic [IW_W-1:0] holding_word_q;
	logic flush_q;
	logic [7:0] working_accumulator_q;
	logic [PC_W-1:0] table_byte_pointer_q;
	logic [7:0] table_data_latch_q;
	logic [SP_W-1:0] return_stack_pointer_q;
	int n_fail = 0;
	int comparisons = 0;
	// Fetch address per instruction cycle and whether its executing word is discarded
	row_type rows [0:6] = '{'{21'h0, 1'b1}, '{21'h2, 1'b0}, '{21'h4, 1'b0},
		'{21'h6, 1'b0}, '{21'h8, 1'b0}, '{21'hc, 1'b1}, '{21'he, 1'b0}};

	fetch_exec_seq u_dut (.clock(clock), .arst_n(arst_n), .prog_addr_q(prog_addr_q),
		.prog_rdata(prog_rdata), .prog_byte_rdata(prog_byte_rdata),
		.prog_byte_we_q(prog_byte_we_q), .prog_byte_wdata_q(prog_byte_wdata_q),
		.data_addr_q(data_addr_q), .data_re_q(data_re_q), .data_rdata(data_rdata),
		.data_we_q(data_we_q), .data_wdata_q(data_wdata_q), .phase_q(phase_q),
		.holding_word_q(holding_word_q), .flush_q(flush_q),
		.working_accumulator_q(working_accumulator_q),
		.table_byte_pointer_q(table_byte_pointer_q),
		.table_data_latch_q(table_data_latch_q),
		.return_stack_pointer_q(return_stack_pointer_q));
	seq_mem_model u_mem (.clock(clock), .prog_addr(prog_addr_q), .prog_rdata(prog_rdata),
		.byte_ptr(table_byte_pointer_q), .prog_byte_rdata(prog_byte_rdata),
		.byte_we(prog_byte_we_q), .byte_wdata(prog_byte_wdata_q), .data_addr(data_addr_q),
		.data_re(data_re_q), .data_rdata(data_rdata), .data_we(data_we_q),
		.data_wdata(data_wdata_q));

	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	task automatic test_done;
		if (n_fail == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : test_done

	task automatic wait_ph2;
		int n = 0;
		@(negedge clock);
		while (phase_q !== PH_TWO && n < 16) begin
			@(negedge clock);
			n++;
		end
		check("phase_two_reached", phase_q, PH_TWO);
	endtask : wait_ph2

	function automatic phase_type next_phase(input phase_type p);
		case (p)
			PH_ONE: next_phase = PH_TWO;
			PH_TWO: next_phase = PH_THREE;
			PH_THREE: next_phase = PH_FOUR;
			default: next_phase = PH_ONE;
		endcase
	endfunction : next_phase

	// Phase order every clock once out of reset
	always @(negedge clock) begin
		if (!arst_n) begin
			ph_ok <= 1'b0;
		end else begin
			if (ph_ok) check("phase", phase_q, next_phase(prev_ph));
			ph_ok <= 1'b1;
			prev_ph <= phase_q;
		end
	end

	initial begin
		#(2000 * 50);
		check("watchdog", 1, 0);
		test_done();
	end

	initial begin
		arst_n = 1'b0;
		// Load after the model has cleared its arrays
		@(negedge clock);
		u_mem.load_word(8'h00, 16'hf0a5);
		u_mem.load_word(8'h04, 16'hee06);
		u_mem.load_word(8'h06, 16'hf000);
		u_mem.load_word(8'h0c, 16'h0008);
		u_mem.load_word(8'h0e, 16'h000c);
		u_mem.load_word(8'h10, 16'hec0c);
		u_mem.load_word(8'h12, 16'hf000);
		u_mem.load_word(8'h14, 16'hd7ff);
		u_mem.load_word(8'h18, 16'h26f9);
		u_mem.load_word(8'h1a, 16'h0c5a);
		repeat (4) @(negedge clock);
		arst_n <= 1'b1;
		for (int i = 0; i < 7; i++) begin
			wait_ph2();
			check("prog_addr", prog_addr_q, rows[i].addr);
			check("prog_addr_lsb", prog_addr_q[0], 1'b0);
			if (i > 0) check("flush", flush_q, rows[i].flush);
			if (i > 0 && !rows[i].flush) check("holding_word", holding_word_q,
				{u_mem.pmem[rows[i-1].addr + 1], u_mem.pmem[rows[i-1].addr]});
		end
		repeat (60) @(negedge clock);
		check("table_latch", table_data_latch_q, 8'ha5);
		check("table_byte_writes", u_mem.byte_writes, 1);
		check("table_byte_value", u_mem.last_byte, 8'ha5);
		check("data_writes", u_mem.data_writes, 0);
		check("loop_addr", prog_addr_q[PC_W-1:2], 19'h5);
		check("stack_entry", u_dut.u_stack.mem_q[1], 21'h14);
		check("stack_ptr_after_return", return_stack_pointer_q, SP_RESET);
		check("accumulator", working_accumulator_q, 8'h5a);
		// Reset in mid-run
		arst_n <= 1'b0;
		@(negedge clock);
		check("rst_phase", phase_q, PH_ONE);
		check("rst_prog_addr", prog_addr_q, PC_RESET);
		check("rst_flush", flush_q, 1'b1);
		check("rst_latch", table_data_latch_q, 8'h00);
		check("rst_stack_ptr", return_stack_pointer_q, SP_RESET);
		repeat (4) @(negedge clock);
		arst_n <= 1'b1;
		wait_ph2();
		check("restart_addr", prog_addr_q, PC_RESET);
		wait_ph2();
		check("restart_next", prog_addr_q, PC_STEP);
		test_done();
	end
endmodule : test_cpu_fetch_execute_sequencer

// >>> rtl/fetch_exec_seq.sv
// Purpose: Four-phase fetch/execute sequencer of an 8-bit core.
// Assumes: Program and data memories answer within one phase.
// Notes: Sequencing, move and table instructions are executed; others are passed on.
// Functional notes
// - Clock divided by four into phases.
// - PC increments phase one, fetch latched phase four.
// - Fetched word enters holding register phase one.
// - Data read phase two, written phase four.
// - Fetch overlaps execute, one per cycle.
// - PC changes flush, taking two cycles.
// - Byte-addressed memory, even-aligned instruction words.
// - PC steps by two, LSb zero.
// - Absolute target loads PC bits 20:1.
// - Relative offset counts words, not bytes.
// - Four two-word ops, second word tagged 1111.
// - Lone second word executes as no-operation.
// - Accumulator added to PC low byte jumps.
// - Table access moves one byte per transfer.
// - Call increments pointer then stores return.
module fetch_exec_seq
	import seq_pkg::*;
(
	// Clock and reset
	input wire logic clock,
	input wire logic arst_n,
	// Program memory
	output logic [PC_W-1:0] prog_addr_q,
	input wire logic [IW_W-1:0] prog_rdata,
	input wire logic [7:0] prog_byte_rdata,
	output logic prog_byte_we_q,
	output logic [7:0] prog_byte_wdata_q,
	// Data memory
	output logic [DA_W-1:0] data_addr_q,
	output logic data_re_q,
	input wire logic [7:0] data_rdata,
	output logic data_we_q,
	output logic [7:0] data_wdata_q,
	// Status
	output phase_type phase_q,
	output logic [IW_W-1:0] holding_word_q,
	output logic flush_q,
	output logic [7:0] working_accumulator_q,
	output logic [PC_W-1:0] table_byte_pointer_q,
	output logic [7:0] table_data_latch_q,
	output logic [SP_W-1:0] return_stack_pointer_q
);
	logic [PC_W-1:0] pc_q;
	logic [IW_W-1:0] fetch_q;
	logic [IW_W-1:0] instruction_holding_register_q;
	logic [IW_W-1:0] first_word_q;
	logic pending_q;
	logic flush_pend_q;
	logic [7:0] operand_q;
	// Return address captured before the redirect overwrites pc_q
	logic [PC_W-1:0] ret_addr_q;
	logic [PC_W-1:0] pc_d;
	logic redirect;
	logic [IW_W-1:0] ir;
	ret_stack_if rs ();

	ret_stack_mem u_stack (
		.clock(clock),
		.port(rs.mem)
	);

	assign ir = instruction_holding_register_q;

	// Phase counter: divide by four
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			phase_q <= PH_ONE;
		end else begin
			unique case (phase_q)
				PH_ONE: phase_q <= PH_TWO;
				PH_TWO: phase_q <= PH_THREE;
				PH_THREE: phase_q <= PH_FOUR;
				PH_FOUR: phase_q <= PH_ONE;
			endcase
		end
	end

	// Executed word classification
	logic is_rbra, is_addpcl, is_retlit, is_test, is_tblrd, is_tblwr;
	logic second_in_seq;
	always_comb begin
		second_in_seq = pending_q && is_second_word(ir);
		is_rbra = !pending_q && !flush_q && ir[15:11] == OP_RBRA_PFX;
		is_addpcl = !pending_q && !flush_q && ir[15:10] == OP_ADDW_PFX && ir[7:0] == PCL_ADDR;
		is_retlit = !pending_q && !flush_q && ir[15:12] == OP_RETLIT_PFX
			&& ir[11:8] == OP_RETLIT_SUB[3:0];
		is_test = !pending_q && !flush_q && ir[15:10] == OP_TESTSKIP_PFX;
		is_tblrd = !pending_q && !flush_q && ir[15:8] == 8'h00 && ir[7:0] == OP_TBLRD_CODE;
		is_tblwr = !pending_q && !flush_q && ir[15:8] == 8'h00 && ir[7:0] == OP_TBLWR_CODE;
	end

	// Redirect target, resolved in phase four
	always_comb begin
		redirect = 1'b0;
		pc_d = pc_q;
		if (second_in_seq && first_word_q[15:9] == OP_GOTO_PFX) begin
			redirect = 1'b1;
			pc_d = {ir[11:0], first_word_q[7:0], 1'b0};
		end else if (second_in_seq && first_word_q[15:9] == OP_CALL_PFX) begin
			redirect = 1'b1;
			pc_d = {ir[11:0], first_word_q[7:0], 1'b0};
		end else if (is_rbra) begin
			redirect = 1'b1;
			pc_d = pc_q - PC_STEP + word_offset(ir[10:0]);
		end else if (is_addpcl) begin
			redirect = 1'b1;
			pc_d = {pc_q[PC_W-1:8], 8'(pc_q[7:0] - PC_STEP[7:0] + working_accumulator_q)};
			pc_d[0] = 1'b0;
		end else if (is_retlit) begin
			redirect = 1'b1;
			pc_d = rs.rdata;
		end else if (is_test && operand_q == 8'h00) begin
			redirect = 1'b1;
			pc_d = pc_q; // skip: discard fetched word only
		end
	end

	// Program counter and fetch
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			pc_q <= PC_RESET;
			prog_addr_q <= PC_RESET;
			fetch_q <= NOP_WORD;
		end else if (phase_q == PH_ONE) begin
			prog_addr_q <= pc_q;
			pc_q <= pc_q + PC_STEP;
		end else if (phase_q == PH_FOUR) begin
			fetch_q <= prog_rdata;
			if (redirect) begin
				pc_q <= pc_d;
			end
		end
	end

	// Instruction holding register and flush
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			instruction_holding_register_q <= NOP_WORD;
			holding_word_q <= NOP_WORD;
			first_word_q <= NOP_WORD;
			pending_q <= 1'b0;
			flush_q <= 1'b1;
			flush_pend_q <= 1'b0;
		end else if (phase_q == PH_FOUR) begin
			flush_pend_q <= redirect;
		end else if (phase_q == PH_ONE) begin
			instruction_holding_register_q <= fetch_q;
			holding_word_q <= fetch_q;
			flush_q <= flush_pend_q;
			// second word follows a two-word first word
			pending_q <= !flush_pend_q && !flush_q && !pending_q && is_two_word(ir);
			first_word_q <= ir;
		end
	end

	// Data memory access
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			data_addr_q <= '0;
			data_re_q <= 1'b0;
			data_we_q <= 1'b0;
			data_wdata_q <= 8'h00;
			operand_q <= 8'h00;
		end else begin
			data_re_q <= 1'b0;
			data_we_q <= 1'b0;
			if (phase_q == PH_ONE) begin
				data_addr_q <= {4'h0, fetch_q[7:0]};
				data_re_q <= 1'b1; // (read in phase two)
			end else if (phase_q == PH_TWO) begin
				operand_q <= data_rdata;
			end else if (phase_q == PH_THREE && second_in_seq
				&& first_word_q[15:12] == OP_MOVE_PFX) begin
				data_addr_q <= ir[11:0];
				data_wdata_q <= operand_q;
				data_we_q <= 1'b1; // (write in phase four)
			end
		end
	end

	// Accumulator, return stack, table path
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			working_accumulator_q <= W_RESET;
			return_stack_pointer_q <= SP_RESET;
			table_byte_pointer_q <= PC_RESET;
			table_data_latch_q <= 8'h00;
			prog_byte_we_q <= 1'b0;
			prog_byte_wdata_q <= 8'h00;
			ret_addr_q <= PC_RESET;
		end else begin
			prog_byte_we_q <= 1'b0;
			if (phase_q == PH_FOUR) begin
				if (second_in_seq && first_word_q[15:9] == OP_CALL_PFX
					&& return_stack_pointer_q != SP_W'(STACK_DEPTH)) begin
					return_stack_pointer_q <= return_stack_pointer_q + 5'h01;
					ret_addr_q <= pc_q - PC_STEP;
				end
				if (is_retlit) begin
					working_accumulator_q <= ir[7:0];
					if (return_stack_pointer_q != SP_RESET) begin
						return_stack_pointer_q <= return_stack_pointer_q - 5'h01;
					end
				end
				if (second_in_seq && first_word_q[15:6] == OP_PTRLOAD_PFX) begin
					table_byte_pointer_q <= PC_W'({first_word_q[3:0], ir[11:0]});
				end
				if (is_tblrd) begin
					table_data_latch_q <= prog_byte_rdata;
				end
				if (is_tblwr) begin
					prog_byte_wdata_q <= table_data_latch_q;
					prog_byte_we_q <= 1'b1;
				end
			end
		end
	end

	// Stack write: pointer bumped first, then entry written next phase
	always_comb begin
		rs.we = phase_q == PH_ONE && flush_pend_q && first_word_q[15:9] == OP_CALL_PFX
			&& pending_q;
		rs.waddr = return_stack_pointer_q;
		rs.wdata = ret_addr_q;
		rs.raddr = return_stack_pointer_q;
	end

	// Assertions
	property p_phase_cycle;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_ONE |=> phase_q == PH_TWO ##1 phase_q == PH_THREE ##1 phase_q == PH_FOUR;
	endproperty
	a_phase_cycle: assert property (p_phase_cycle) else $error("phase order broken");

	property p_pc_step;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_ONE |=> pc_q == $past(pc_q) + PC_STEP;
	endproperty
	a_pc_step: assert property (p_pc_step) else $error("pc not stepped by two");

	property p_pc_even;
		@(posedge clock) disable iff (!arst_n)
		1'b1 |-> pc_q[0] == 1'b0 && prog_addr_q[0] == 1'b0;
	endproperty
	a_pc_even: assert property (p_pc_even) else $error("pc lsb set");

	property p_ir_load;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_ONE |=> instruction_holding_register_q == $past(fetch_q);
	endproperty
	a_ir_load: assert property (p_ir_load) else $error("holding register not loaded");

	property p_data_write_phase;
		@(posedge clock) disable iff (!arst_n)
		data_we_q |-> phase_q == PH_FOUR;
	endproperty
	a_data_write_phase: assert property (p_data_write_phase) else $error("write off phase");

	property p_data_read_phase;
		@(posedge clock) disable iff (!arst_n)
		data_re_q |-> phase_q == PH_TWO;
	endproperty
	a_data_read_phase: assert property (p_data_read_phase) else $error("read off phase");

	property p_flush;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_FOUR && redirect |=> ##1 flush_q;
	endproperty
	a_flush: assert property (p_flush) else $error("branch did not flush");

	property p_goto_target;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_FOUR && second_in_seq && first_word_q[15:9] == OP_GOTO_PFX
		|=> pc_q[20:1] == {$past(ir[11:0]), $past(first_word_q[7:0])};
	endproperty
	a_goto_target: assert property (p_goto_target) else $error("bad absolute target");

	property p_lone_second_nop;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_FOUR && !pending_q && is_second_word(ir) |-> !redirect;
	endproperty
	a_lone_second_nop: assert property (p_lone_second_nop) else $error("lone word acted");

	property p_call_push;
		@(posedge clock) disable iff (!arst_n)
		rs.we && $past(return_stack_pointer_q) != SP_W'(STACK_DEPTH)
		|-> return_stack_pointer_q == $past(return_stack_pointer_q) + 5'h01
			&& rs.wdata == prog_addr_q;
	endproperty
	a_call_push: assert property (p_call_push) else $error("push order or value wrong");

	property p_rbra_target;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_FOUR && is_rbra
		|=> pc_q[20:1] == $past(prog_addr_q[20:1]) + 20'($signed($past(ir[10:0])));
	endproperty
	a_rbra_target: assert property (p_rbra_target) else $error("bad relative target");

	property p_addpcl_jump;
		@(posedge clock) disable iff (!arst_n)
		phase_q == PH_FOUR && is_addpcl && !working_accumulator_q[0]
		|=> pc_q[7:0] == 8'($past(prog_addr_q[7:0]) + $past(working_accumulator_q));
	endproperty
	a_addpcl_jump: assert property (p_addpcl_jump) else $error("computed jump wrong");
endmodule : fetch_exec_seq

// >>> rtl/ret_stack_if.sv
// Purpose: Write/read port bundle for the return stack memory.
// Assumes: Single clock domain.
// Notes: Read data is registered inside the memory.
interface ret_stack_if;
	import seq_pkg::*;
	logic we;
	logic [SP_W-1:0] waddr;
	logic [PC_W-1:0] wdata;
	logic [SP_W-1:0] raddr;
	logic [PC_W-1:0] rdata;
	modport core (output we, waddr, wdata, raddr, input rdata);
	modport mem (input we, waddr, wdata, raddr, output rdata);
endinterface : ret_stack_if

// >>> rtl/ret_stack_mem.sv
// Purpose: Return address storage, registered read.
// Assumes: Entry 0 has no storage meaning; reads as zero.
// Notes: Depth is a parameter; width is PC_W from the package.
module ret_stack_mem
	import seq_pkg::*;
#(
	parameter int DEPTH = STACK_DEPTH + 1
) (
	// Clock
	input wire logic clock,
	// Port bundle
	ret_stack_if.mem port
);
	logic [PC_W-1:0] mem_q [DEPTH];

	always_ff @(posedge clock) begin
		if (port.we) begin
			mem_q[port.waddr] <= port.wdata;
		end
	end

	always_ff @(posedge clock) begin
		port.rdata <= (port.raddr == SP_RESET) ? PC_RESET : mem_q[port.raddr];
	end
endmodule : ret_stack_mem

// >>> rtl/seq_pkg.sv
// Purpose: Constants and types shared by the fetch/execute sequencer.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Phase, opcode and width constants live here.
package seq_pkg;
	localparam int PC_W = 21;
	localparam int IW_W = 16;
	localparam int DA_W = 12;
	localparam int SP_W = 5;
	localparam int STACK_DEPTH = 31;
	localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
	localparam logic [SP_W-1:0] SP_RESET = 5'h00;
	localparam logic [7:0] W_RESET = 8'h00;
	// Top nibble of a second word
	localparam logic [3:0] SECOND_WORD_TAG = 4'hf;
	localparam logic [IW_W-1:0] NOP_WORD = 16'h0000;
	// Opcode prefixes (top bits of first word)
	localparam logic [3:0] OP_MOVE_PFX = 4'hc;
	localparam logic [6:0] OP_GOTO_PFX = 7'h77;
	localparam logic [6:0] OP_CALL_PFX = 7'h76;
	localparam logic [9:0] OP_PTRLOAD_PFX = 10'h3b8;
	localparam logic [4:0] OP_RBRA_PFX = 5'h1a;
	localparam logic [5:0] OP_TESTSKIP_PFX = 6'h19;
	localparam logic [5:0] OP_ADDW_PFX = 6'h09;
	localparam logic [3:0] OP_RETLIT_PFX = 4'h0;
	localparam logic [7:0] OP_RETLIT_SUB = 8'h0c;
	localparam logic [7:0] OP_TBLRD_CODE = 8'h08;
	localparam logic [7:0] OP_TBLWR_CODE = 8'h0c;
	localparam logic [7:0] PCL_ADDR = 8'hf9;

	typedef enum logic [1:0] {
		PH_ONE = 2'b00,
		PH_TWO = 2'b01,
		PH_THREE = 2'b11,
		PH_FOUR = 2'b10
	} phase_type;

	// Sign-extend 11-bit word offset to a byte offset
	function automatic logic [PC_W-1:0] word_offset(input logic [10:0] off);
		word_offset = PC_W'({{(PC_W-12){off[10]}}, off, 1'b0});
	endfunction : word_offset

	function automatic logic is_second_word(input logic [IW_W-1:0] w);
		is_second_word = (w[15:12] == SECOND_WORD_TAG);
	endfunction : is_second_word

	function automatic logic is_two_word(input logic [IW_W-1:0] w);
		is_two_word = (w[15:12] == OP_MOVE_PFX) || (w[15:9] == OP_GOTO_PFX)
			|| (w[15:9] == OP_CALL_PFX) || (w[15:6] == OP_PTRLOAD_PFX);
	endfunction : is_two_word
endpackage : seq_pkg
